// File: logic/dtc_consts.vh
// register map, field positions and encodings of the dual timer/counter
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

`define DTC_AW              11
`define DTC_ADDR_CONTROL    11'h410
`define DTC_ADDR_EXT_STATUS 11'h411
`define DTC_ADDR_SYS_CONFIG 11'h440
`define DTC_ADDR_U0_LOW     11'h450
`define DTC_ADDR_U0_HIGH    11'h451
`define DTC_ADDR_U1_LOW     11'h452
`define DTC_ADDR_U1_HIGH    11'h453
`define DTC_ADDR_U0_RLD_LO  11'h454
`define DTC_ADDR_U0_RLD_HI  11'h455
`define DTC_ADDR_U1_RLD_LO  11'h456
`define DTC_ADDR_U1_RLD_HI  11'h457
`define DTC_ADDR_MODE_SEL   11'h45c

`define DTC_RST8            8'h00
`define DTC_RST16           16'h0000
`define DTC_RST6            6'h00
`define DTC_RST4            4'h0
`define DTC_RST2            2'h0

// timer_control fields
`define DTC_CTL_U1_FLAG     7
`define DTC_CTL_U1_RUN      6
`define DTC_CTL_U0_FLAG     5
`define DTC_CTL_U0_RUN      4
`define DTC_CTL_EXT_HI      3
`define DTC_CTL_EXT_LO      0

// timer_extended_status fields
`define DTC_EST_U1_OE       2
`define DTC_EST_U0_OE       0

// system_config_reg prescale field
`define DTC_SCR_PS_HI       3
`define DTC_SCR_PS_LO       2

// timer_mode_select fields
`define DTC_MOD_U1_GATE     7
`define DTC_MOD_U1_SRC      6
`define DTC_MOD_U1_MHI      5
`define DTC_MOD_U1_MLO      4
`define DTC_MOD_U0_GATE     3
`define DTC_MOD_U0_SRC      2
`define DTC_MOD_U0_MHI      1
`define DTC_MOD_U0_MLO      0

// operating modes
`define DTC_MODE_RELOAD16   2'h0
`define DTC_MODE_FREE16     2'h1
`define DTC_MODE_RELOAD8    2'h2
`define DTC_MODE_SPLIT      2'h3

// prescale selections
`define DTC_PS_DIV4         2'h0
`define DTC_PS_DIV16        2'h1
`define DTC_PS_DIV64        2'h2
`define DTC_PS_MASK4        6'h03
`define DTC_PS_MASK16       6'h0f
`define DTC_PS_MASK64       6'h3f

`define DTC_ONE6            6'h01
`define DTC_ONE8            8'h01
`define DTC_ONE16           16'h0001
`define DTC_ONES8           8'hff
`define DTC_ONES16          16'hffff

`endif

// File: logic/dtc_prescale.v
// free-running timebase divider with sampler strobe
`timescale 1ns/10ps
`include "dtc_consts.vh"
module dtc_prescale (
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  input  wire [1:0] sel_in,
  output reg        tick_out,
  output reg        sample_out
);
  reg  [5:0] cnt_q;
  reg  [5:0] mask;

  always @*
  begin
    case (sel_in)
      `DTC_PS_DIV4:  mask = `DTC_PS_MASK4;
      `DTC_PS_DIV16: mask = `DTC_PS_MASK16;
      default:       mask = `DTC_PS_MASK64;
    endcase
  end

  // enable pulse, not a derived clock, keeps one clock domain
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q      <= `DTC_RST6;
      tick_out   <= 1'b0;
      sample_out <= 1'b0;
    end
    else
    begin
      cnt_q      <= cnt_q + `DTC_ONE6;
      tick_out   <= ((cnt_q & mask) == mask);
      sample_out <= cnt_q[0];
    end
  end
endmodule // dtc_prescale

// File: logic/dtc_evsync.v
// pin synchroniser sampled every other clock, with falling-edge pulse
`timescale 1ns/10ps
module dtc_evsync (
  input  wire clk_sys_in,
  input  wire rst_n_in,
  input  wire sample_in,
  input  wire pin_in,
  output reg  level_out,
  output reg  fall_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // idle high so no edge is seen out of reset
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      s1_q      <= 1'b1;
      s2_q      <= 1'b1;
      s3_q      <= 1'b1;
      level_out <= 1'b1;
      fall_out  <= 1'b0;
    end
    else
    begin
      fall_out <= 1'b0;
      if (sample_in)
      begin
        s1_q <= pin_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
        begin
          level_out <= s3_q;
          fall_out  <= level_out & ~s3_q;
        end
      end
    end
  end
endmodule // dtc_evsync

// File: logic/dtc_timer.v
// dual 16-bit timer/counter with shared prescaled timebase
// Functional notes
// - timebase tick derived from oscillator by prescale field in config reg
// - prescale divides the oscillator by four, sixteen or sixty-four
// - one prescale setting feeds every unit in timer mode
// - counter mode increments on each falling edge of the event pin
// - event pins sampled every two clocks; count rate at most clock/8
// - units count upward in every mode except unit 1 in mode 3, which holds
// - count-source bit picks timebase ticks or pin edges
// - each unit has four modes from its own two-bit field
// - mode 0 is a 16-bit counter with automatic reload
// - count registers read live without stopping the count
// - mode register: unit 1 fields upper nibble, unit 0 lower, reset zero
// - control register flags, runs and external bits, resetting to zero
// - extended status holds output enables at bits 2 and 0
// - 8-bit bus; wide write keeps low byte, wide read upper undefined
// - mode 0 high overflow sets flag and reloads both bytes
// - mode 2 low overflow sets flag, reloads low byte, high kept
// - mode 3 unit 1 holds; unit 0 high byte uses unit 1 run/flag
`timescale 1ns/10ps
`include "dtc_consts.vh"
module dtc_timer (
  input  wire                clk_sys_in,
  input  wire                rst_n_in,
  input  wire [`DTC_AW-1:0]  reg_addr_in,
  input  wire                reg_wr_en_in,
  input  wire                reg_rd_en_in,
  input  wire [15:0]         reg_wdata_in,
  output reg  [15:0]         reg_rdata_out,
  input  wire                unit0_event_in,
  input  wire                unit1_event_in,
  input  wire                unit0_gate_pin_in,
  input  wire                unit1_gate_pin_in,
  output reg                 unit0_wave_out,
  output reg                 unit1_wave_out,
  output reg                 unit0_overflow_out,
  output reg                 unit1_overflow_out
);
  reg        unit0_overflow_flag_q;
  reg        unit1_overflow_flag_q;
  reg        unit0_run_q;
  reg        unit1_run_q;
  reg  [3:0] ext_int_ctl_q;
  reg        unit0_output_enable_q;
  reg        unit1_output_enable_q;
  reg        prescale_sel_hi_q;
  reg        prescale_sel_lo_q;
  reg  [7:0] timer_mode_select_q;
  reg  [7:0] unit0_count_low_q;
  reg  [7:0] unit0_count_high_q;
  reg  [7:0] unit1_count_low_q;
  reg  [7:0] unit1_count_high_q;
  reg  [7:0] u0_reload_low_byte_q;
  reg  [7:0] u0_reload_high_byte_q;
  reg  [7:0] u1_reload_low_byte_q;
  reg  [7:0] u1_reload_high_byte_q;

  wire       shared_timebase_tick;
  wire       sample_strobe;
  wire       ev0_fall;
  wire       ev1_fall;
  wire       gate0_level;
  wire       gate1_level;

  dtc_prescale u_prescale (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sel_in     ({prescale_sel_hi_q, prescale_sel_lo_q}),
    .tick_out   (shared_timebase_tick),
    .sample_out (sample_strobe)
  );

  dtc_evsync u_ev0 (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sample_in  (sample_strobe),
    .pin_in     (unit0_event_in),
    .level_out  (),
    .fall_out   (ev0_fall)
  );

  dtc_evsync u_ev1 (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sample_in  (sample_strobe),
    .pin_in     (unit1_event_in),
    .level_out  (),
    .fall_out   (ev1_fall)
  );

  dtc_evsync u_gate0 (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sample_in  (sample_strobe),
    .pin_in     (unit0_gate_pin_in),
    .level_out  (gate0_level),
    .fall_out   ()
  );

  dtc_evsync u_gate1 (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sample_in  (sample_strobe),
    .pin_in     (unit1_gate_pin_in),
    .level_out  (gate1_level),
    .fall_out   ()
  );

  wire [1:0] u0_mode = timer_mode_select_q[`DTC_MOD_U0_MHI:`DTC_MOD_U0_MLO];
  wire [1:0] u1_mode = timer_mode_select_q[`DTC_MOD_U1_MHI:`DTC_MOD_U1_MLO];
  wire       u0_split = (u0_mode == `DTC_MODE_SPLIT);

  // gate open when gate bit clear or gate pin high
  wire u0_gate_ok = ~timer_mode_select_q[`DTC_MOD_U0_GATE] | gate0_level;
  wire u1_gate_ok = ~timer_mode_select_q[`DTC_MOD_U1_GATE] | gate1_level;
  wire u0_src = timer_mode_select_q[`DTC_MOD_U0_SRC] ?
                ev0_fall : shared_timebase_tick;
  wire u1_src = timer_mode_select_q[`DTC_MOD_U1_SRC] ?
                ev1_fall : shared_timebase_tick;
  wire u0_en  = unit0_run_q & u0_gate_ok & u0_src;
  wire u1_en  = unit1_run_q & u1_gate_ok & u1_src &
                (u1_mode != `DTC_MODE_SPLIT);
  // split high byte always times, borrowing unit 1 run
  wire u0h_en = u0_split & unit1_run_q & shared_timebase_tick;

  wire [15:0] u0_cnt = {unit0_count_high_q, unit0_count_low_q};
  wire [15:0] u1_cnt = {unit1_count_high_q, unit1_count_low_q};
  wire [15:0] u0_inc = u0_cnt + `DTC_ONE16;
  wire [15:0] u1_inc = u1_cnt + `DTC_ONE16;
  wire [7:0]  u0l_inc = unit0_count_low_q + `DTC_ONE8;
  wire [7:0]  u1l_inc = unit1_count_low_q + `DTC_ONE8;
  wire [7:0]  u0h_inc = unit0_count_high_q + `DTC_ONE8;

  reg  [15:0] u0_next;
  reg  [15:0] u1_next;
  reg         u0_ovf;
  reg         u1_ovf;
  reg         u0h_ovf;

  always @*
  begin
    u0_next = u0_cnt;
    u0_ovf  = 1'b0;
    u0h_ovf = 1'b0;
    if (u0_en)
    begin
      case (u0_mode)
        `DTC_MODE_RELOAD16:
        begin
          if (u0_cnt == `DTC_ONES16)
          begin
            u0_next = {u0_reload_high_byte_q, u0_reload_low_byte_q};
            u0_ovf  = 1'b1;
          end
          else
            u0_next = u0_inc;
        end
        `DTC_MODE_FREE16:
        begin
          u0_next = u0_inc;
          u0_ovf  = (u0_cnt == `DTC_ONES16);
        end
        `DTC_MODE_RELOAD8:
        begin
          if (unit0_count_low_q == `DTC_ONES8)
          begin
            u0_next[7:0] = u0_reload_low_byte_q;
            u0_ovf       = 1'b1;
          end
          else
            u0_next[7:0] = u0l_inc;
        end
        default:
        begin
          u0_next[7:0] = u0l_inc;
          u0_ovf       = (unit0_count_low_q == `DTC_ONES8);
        end
      endcase
    end
    if (u0h_en)
    begin
      u0_next[15:8] = u0h_inc;
      u0h_ovf       = (unit0_count_high_q == `DTC_ONES8);
    end
  end

  always @*
  begin
    u1_next = u1_cnt;
    u1_ovf  = 1'b0;
    if (u1_en)
    begin
      case (u1_mode)
        `DTC_MODE_RELOAD16:
        begin
          if (u1_cnt == `DTC_ONES16)
          begin
            u1_next = {u1_reload_high_byte_q, u1_reload_low_byte_q};
            u1_ovf  = 1'b1;
          end
          else
            u1_next = u1_inc;
        end
        `DTC_MODE_FREE16:
        begin
          u1_next = u1_inc;
          u1_ovf  = (u1_cnt == `DTC_ONES16);
        end
        `DTC_MODE_RELOAD8:
        begin
          if (unit1_count_low_q == `DTC_ONES8)
          begin
            u1_next[7:0] = u1_reload_low_byte_q;
            u1_ovf       = 1'b1;
          end
          else
            u1_next[7:0] = u1l_inc;
        end
        default:
          u1_next = u1_cnt;
      endcase
    end
  end

  // while unit 0 is split, unit 1 runs but loses its flag
  wire ev_flag0 = u0_ovf;
  wire ev_flag1 = u0_split ? u0h_ovf : u1_ovf;
  // output enable diverts the overflow from flag to waveform
  wire set_flag0 = ev_flag0 & ~unit0_output_enable_q;
  wire set_flag1 = ev_flag1 & ~unit1_output_enable_q;

  wire       wr = reg_wr_en_in;
  // only the low byte of a wide write lands
  wire [7:0] wd = reg_wdata_in[7:0];
  wire wr_ctl  = wr & (reg_addr_in == `DTC_ADDR_CONTROL);
  wire wr_est  = wr & (reg_addr_in == `DTC_ADDR_EXT_STATUS);
  wire wr_scr  = wr & (reg_addr_in == `DTC_ADDR_SYS_CONFIG);
  wire wr_mod  = wr & (reg_addr_in == `DTC_ADDR_MODE_SEL);
  wire wr_u0l  = wr & (reg_addr_in == `DTC_ADDR_U0_LOW);
  wire wr_u0h  = wr & (reg_addr_in == `DTC_ADDR_U0_HIGH);
  wire wr_u1l  = wr & (reg_addr_in == `DTC_ADDR_U1_LOW);
  wire wr_u1h  = wr & (reg_addr_in == `DTC_ADDR_U1_HIGH);

  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      unit0_overflow_flag_q <= 1'b0;
      unit1_overflow_flag_q <= 1'b0;
      unit0_run_q           <= 1'b0;
      unit1_run_q           <= 1'b0;
      ext_int_ctl_q         <= `DTC_RST4;
      unit0_output_enable_q <= 1'b0;
      unit1_output_enable_q <= 1'b0;
      prescale_sel_hi_q     <= 1'b0;
      prescale_sel_lo_q     <= 1'b0;
      timer_mode_select_q   <= `DTC_RST8;
      unit0_count_low_q     <= `DTC_RST8;
      unit0_count_high_q    <= `DTC_RST8;
      unit1_count_low_q     <= `DTC_RST8;
      unit1_count_high_q    <= `DTC_RST8;
      u0_reload_low_byte_q  <= `DTC_RST8;
      u0_reload_high_byte_q <= `DTC_RST8;
      u1_reload_low_byte_q  <= `DTC_RST8;
      u1_reload_high_byte_q <= `DTC_RST8;
      unit0_wave_out        <= 1'b0;
      unit1_wave_out        <= 1'b0;
      unit0_overflow_out    <= 1'b0;
      unit1_overflow_out    <= 1'b0;
    end
    else
    begin
      // a set arriving with a software clear wins
      unit0_overflow_flag_q <= set_flag0 |
        (wr_ctl ? wd[`DTC_CTL_U0_FLAG] : unit0_overflow_flag_q);
      unit1_overflow_flag_q <= set_flag1 |
        (wr_ctl ? wd[`DTC_CTL_U1_FLAG] : unit1_overflow_flag_q);
      if (wr_ctl)
      begin
        unit0_run_q   <= wd[`DTC_CTL_U0_RUN];
        unit1_run_q   <= wd[`DTC_CTL_U1_RUN];
        ext_int_ctl_q <= wd[`DTC_CTL_EXT_HI:`DTC_CTL_EXT_LO];
      end
      if (wr_est)
      begin
        unit0_output_enable_q <= wd[`DTC_EST_U0_OE];
        unit1_output_enable_q <= wd[`DTC_EST_U1_OE];
      end
      if (wr_scr)
      begin
        prescale_sel_hi_q <= wd[`DTC_SCR_PS_HI];
        prescale_sel_lo_q <= wd[`DTC_SCR_PS_LO];
      end
      if (wr_mod)
        timer_mode_select_q <= wd;
      // software load of a count byte takes priority over counting
      unit0_count_low_q  <= wr_u0l ? wd : u0_next[7:0];
      unit0_count_high_q <= wr_u0h ? wd : u0_next[15:8];
      unit1_count_low_q  <= wr_u1l ? wd : u1_next[7:0];
      unit1_count_high_q <= wr_u1h ? wd : u1_next[15:8];
      if (wr & (reg_addr_in == `DTC_ADDR_U0_RLD_LO))
        u0_reload_low_byte_q <= wd;
      if (wr & (reg_addr_in == `DTC_ADDR_U0_RLD_HI))
        u0_reload_high_byte_q <= wd;
      if (wr & (reg_addr_in == `DTC_ADDR_U1_RLD_LO))
        u1_reload_low_byte_q <= wd;
      if (wr & (reg_addr_in == `DTC_ADDR_U1_RLD_HI))
        u1_reload_high_byte_q <= wd;
      if (ev_flag0 & unit0_output_enable_q)
        unit0_wave_out <= ~unit0_wave_out;
      if (ev_flag1 & unit1_output_enable_q)
        unit1_wave_out <= ~unit1_wave_out;
      unit0_overflow_out <= ev_flag0;
      unit1_overflow_out <= ev_flag1;
    end
  end

  reg [7:0] rd_mux;

  always @*
  begin
    rd_mux = `DTC_RST8;
    case (reg_addr_in)
      `DTC_ADDR_CONTROL:
      begin
        rd_mux[`DTC_CTL_U1_FLAG] = unit1_overflow_flag_q;
        rd_mux[`DTC_CTL_U1_RUN]  = unit1_run_q;
        rd_mux[`DTC_CTL_U0_FLAG] = unit0_overflow_flag_q;
        rd_mux[`DTC_CTL_U0_RUN]  = unit0_run_q;
        rd_mux[`DTC_CTL_EXT_HI:`DTC_CTL_EXT_LO] = ext_int_ctl_q;
      end
      `DTC_ADDR_EXT_STATUS:
      begin
        rd_mux[`DTC_EST_U1_OE] = unit1_output_enable_q;
        rd_mux[`DTC_EST_U0_OE] = unit0_output_enable_q;
      end
      `DTC_ADDR_SYS_CONFIG:
      begin
        rd_mux[`DTC_SCR_PS_HI] = prescale_sel_hi_q;
        rd_mux[`DTC_SCR_PS_LO] = prescale_sel_lo_q;
      end
      `DTC_ADDR_MODE_SEL:   rd_mux = timer_mode_select_q;
      `DTC_ADDR_U0_LOW:     rd_mux = unit0_count_low_q;
      `DTC_ADDR_U0_HIGH:    rd_mux = unit0_count_high_q;
      `DTC_ADDR_U1_LOW:     rd_mux = unit1_count_low_q;
      `DTC_ADDR_U1_HIGH:    rd_mux = unit1_count_high_q;
      `DTC_ADDR_U0_RLD_LO:  rd_mux = u0_reload_low_byte_q;
      `DTC_ADDR_U0_RLD_HI:  rd_mux = u0_reload_high_byte_q;
      `DTC_ADDR_U1_RLD_LO:  rd_mux = u1_reload_low_byte_q;
      `DTC_ADDR_U1_RLD_HI:  rd_mux = u1_reload_high_byte_q;
      default:              rd_mux = `DTC_RST8;
    endcase
  end

  // upper byte is undefined; it is driven as zero
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= `DTC_RST16;
    else if (reg_rd_en_in)
      reg_rdata_out <= {`DTC_RST8, rd_mux};
  end
endmodule // dtc_timer

// File: tb/dtc_timer_props.sv
// port assertions and covers for the dual timer/counter
`timescale 1ns/10ps
`include "dtc_consts.vh"
module dtc_chk (
  input wire               clk_sys_in,
  input wire               rst_n_in,
  input wire [`DTC_AW-1:0] reg_addr_in,
  input wire               reg_wr_en_in,
  input wire               reg_rd_en_in,
  input wire [15:0]        reg_wdata_in,
  input wire [15:0]        reg_rdata_out,
  input wire               unit0_wave_out,
  input wire               unit0_overflow_out,
  input wire               unit1_overflow_out
);
  wire mapped_w = reg_addr_in[10:1] == 10'h208 ||
                  reg_addr_in == `DTC_ADDR_SYS_CONFIG ||
                  reg_addr_in[10:3] == 8'h8a ||
                  reg_addr_in == `DTC_ADDR_MODE_SEL;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  hi_byte_zero_a: assert property (reg_rdata_out[15:8] == 8'h00)
    else $error("read data upper byte not zero");
  unmapped_zero_a: assert property (reg_rd_en_in && !mapped_w
    |=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!$past(reg_rd_en_in)
    |-> $stable(reg_rdata_out)) else $error("read data moved");
  mode_rdback_a: assert property (reg_wr_en_in &&
    reg_addr_in == `DTC_ADDR_MODE_SEL ##1 reg_rd_en_in && !reg_wr_en_in
    && reg_addr_in == `DTC_ADDR_MODE_SEL |=> reg_rdata_out[7:0] ==
    $past(reg_wdata_in[7:0], 2)) else $error("mode readback wrong");
  oe_rdback_a: assert property (reg_wr_en_in &&
    reg_addr_in == `DTC_ADDR_EXT_STATUS ##1 reg_rd_en_in && !reg_wr_en_in
    && reg_addr_in == `DTC_ADDR_EXT_STATUS |=> reg_rdata_out[7:0] ==
    ($past(reg_wdata_in[7:0], 2) & 8'h05)) else $error("status readback");
  ovf0_gap_a: assert property (unit0_overflow_out
    |=> !unit0_overflow_out [*3]) else $error("unit0 overflow too close");
  ovf1_gap_a: assert property (unit1_overflow_out
    |=> !unit1_overflow_out [*3]) else $error("unit1 overflow too close");
  rst_clear_a: assert property (rst_n_in && !$past(rst_n_in)
    |-> !unit0_overflow_out && !unit1_overflow_out && !unit0_wave_out &&
    reg_rdata_out == 16'h0000) else $error("outputs not clear at reset");
  wave_cause_a: assert property ($changed(unit0_wave_out)
    |-> ##[0:3] $past(unit0_overflow_out, 2))
    else $error("wave toggled without overflow");
  cover property (unit0_overflow_out);
  cover property (unit1_overflow_out);
  cover property ($changed(unit0_wave_out));
endmodule // dtc_chk

bind dtc_timer dtc_chk u_chk (
  .clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wr_en_in, .reg_rd_en_in,
  .reg_wdata_in, .reg_rdata_out, .unit0_wave_out, .unit0_overflow_out,
  .unit1_overflow_out
);

// File: tb/dtc_ev_src.sv
// event pin source, idle high, levels changed at falling edges
`timescale 1ns/10ps
module dtc_ev_src (
  input  wire clk_sys_in,
  output reg  pin_out
);
  initial pin_out = 1'b1;
  // four clocks per level: margin over the sampler's every-other-clock look
  task pulses(input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1)
    begin
      repeat (4) @(negedge clk_sys_in);
      pin_out = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      pin_out = 1'b1;
    end
  endtask
endmodule // dtc_ev_src

// File: tb/tb.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/10ps
`include "dtc_consts.vh"
`define CHK(nm, ex, gt) begin n_tests = n_tests + 1; \
  if ((gt) !== (ex)) begin err_count = err_count + 1; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb;
  reg                clk_sys_in;
  reg                rst_n_in;
  reg  [`DTC_AW-1:0] reg_addr_in;
  reg                reg_wr_en_in;
  reg                reg_rd_en_in;
  reg  [15:0]        reg_wdata_in;
  wire [15:0]        reg_rdata_out;
  wire               ev0_w;
  wire               ev1_w;
  wire               wave0_w;
  wire               wave1_w;
  reg  [7:0]         fl_q;
  wire               ovf0_w;
  wire               ovf1_w;
  reg  [15:0]        rd_q;
  reg  [15:0]        cnt_q;
  reg  [15:0]        c0_q;
  integer            err_count;
  integer            n_tests;
  integer            i;
  integer            ex;
  logic [`DTC_AW-1:0] atab [8] = '{`DTC_ADDR_CONTROL, `DTC_ADDR_EXT_STATUS,
    `DTC_ADDR_U0_LOW, `DTC_ADDR_U0_HIGH, `DTC_ADDR_U1_LOW, `DTC_ADDR_U1_HIGH,
    `DTC_ADDR_MODE_SEL, 11'h412};

  dtc_timer u_dut (
    .clk_sys_in         (clk_sys_in),
    .rst_n_in           (rst_n_in),
    .reg_addr_in        (reg_addr_in),
    .reg_wr_en_in       (reg_wr_en_in),
    .reg_rd_en_in       (reg_rd_en_in),
    .reg_wdata_in       (reg_wdata_in),
    .reg_rdata_out      (reg_rdata_out),
    .unit0_event_in     (ev0_w),
    .unit1_event_in     (ev1_w),
    .unit0_gate_pin_in  (1'b1),
    .unit1_gate_pin_in  (1'b1),
    .unit0_wave_out     (wave0_w),
    .unit1_wave_out     (wave1_w),
    .unit0_overflow_out (ovf0_w),
    .unit1_overflow_out (ovf1_w)
  );
  dtc_ev_src u_src0 (.clk_sys_in(clk_sys_in), .pin_out(ev0_w));
  dtc_ev_src u_src1 (.clk_sys_in(clk_sys_in), .pin_out(ev1_w));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // idle cycle after each write so the strobe is never re-raised at once
  task wr(input [`DTC_AW-1:0] a, input [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = {8'h00, d};
    reg_wr_en_in = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_en_in = 1'b0;
    @(negedge clk_sys_in);
  endtask
  task rd(input [`DTC_AW-1:0] a);
    reg_addr_in = a;
    reg_rd_en_in = 1'b1;
    @(negedge clk_sys_in);
    reg_rd_en_in = 1'b0;
    @(negedge clk_sys_in);
    rd_q = reg_rdata_out;
  endtask
  task wrrd(input [`DTC_AW-1:0] a, input [15:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_en_in = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_en_in = 1'b0;
    rd(a);
  endtask
  // counters are stopped first, since low then high is not atomic
  task rd16(input [`DTC_AW-1:0] a);
    rd(a);
    cnt_q[7:0] = rd_q[7:0];
    rd(a | 11'h001);
    cnt_q[15:8] = rd_q[7:0];
  endtask
  task clr;
    wr(`DTC_ADDR_U0_LOW, 8'h00);
    wr(`DTC_ADDR_U0_HIGH, 8'h00);
    wr(`DTC_ADDR_U1_LOW, 8'h00);
    wr(`DTC_ADDR_U1_HIGH, 8'h00);
  endtask
  task wait_ovf(input integer u);
    for (i = 0; i < 200 && (u ? ovf1_w : ovf0_w) !== 1'b1; i = i + 1)
      @(negedge clk_sys_in);
    // flags captured before the stop write, which clears them
    rd(`DTC_ADDR_CONTROL);
    fl_q = rd_q[7:0];
    wr(`DTC_ADDR_CONTROL, 8'h00);
    `CHK("overflow seen", 1'b1, i < 200)
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #(60000 * 50);
    err_count = err_count + 1;
    summarize;
  end

  initial
  begin
    err_count = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    reg_addr_in = 11'h000;
    reg_wr_en_in = 1'b0;
    reg_rd_en_in = 1'b0;
    reg_wdata_in = 16'h0000;
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      rd(atab[k]);
      `CHK("reset value", 16'h0000, rd_q)
    end
    $display("test reset done");
    wrrd(`DTC_ADDR_MODE_SEL, 16'h00a5);
    `CHK("mode reg", 8'ha5, rd_q[7:0])
    wrrd(`DTC_ADDR_EXT_STATUS, 16'h0005);
    `CHK("status reg", 8'h05, rd_q[7:0])
    wrrd(`DTC_ADDR_CONTROL, 16'h000f);
    `CHK("control reg", 8'h0f, rd_q[7:0])
    wrrd(`DTC_ADDR_U1_LOW, 16'hab12);
    `CHK("wide write", 16'h0012, rd_q)
    wr(`DTC_ADDR_CONTROL, 8'h00);
    wr(`DTC_ADDR_EXT_STATUS, 8'h00);
    $display("test registers done");
    for (int p = 0; p < 3; p++)
    begin
      wr(`DTC_ADDR_SYS_CONFIG, {4'h0, p[1:0], 2'b00});
      wr(`DTC_ADDR_MODE_SEL, 8'h11);
      clr;
      wr(`DTC_ADDR_CONTROL, 8'h50);
      repeat (640) @(negedge clk_sys_in);
      rd(`DTC_ADDR_U0_LOW);
      ex = 642 / (4 << (2 * p));
      `CHK("live read", 1'b1, rd_q[7:0] >= ex - 2 && rd_q[7:0] <= ex + 2)
      repeat (640) @(negedge clk_sys_in);
      wr(`DTC_ADDR_CONTROL, 8'h00);
      ex = 1284 / (4 << (2 * p));
      rd16(`DTC_ADDR_U0_LOW);
      c0_q = cnt_q;
      `CHK("timer rate", 1'b1, c0_q >= ex - 3 && c0_q <= ex + 3)
      rd16(`DTC_ADDR_U1_LOW);
      `CHK("shared rate", c0_q, cnt_q)
    end
    $display("test prescale done");
    wr(`DTC_ADDR_MODE_SEL, 8'h55);
    clr;
    wr(`DTC_ADDR_CONTROL, 8'h50);
    fork
      u_src0.pulses(10);
      u_src1.pulses(5);
    join
    repeat (8) @(negedge clk_sys_in);
    wr(`DTC_ADDR_CONTROL, 8'h00);
    rd16(`DTC_ADDR_U0_LOW);
    `CHK("events unit0", 16'd10, cnt_q)
    rd16(`DTC_ADDR_U1_LOW);
    `CHK("events unit1", 16'd5, cnt_q)
    $display("test counter done");
    wr(`DTC_ADDR_SYS_CONFIG, 8'h00);
    wr(`DTC_ADDR_MODE_SEL, 8'h00);
    wr(`DTC_ADDR_EXT_STATUS, 8'h01);
    wr(`DTC_ADDR_U0_RLD_LO, 8'hfc);
    wr(`DTC_ADDR_U0_RLD_HI, 8'hff);
    wr(`DTC_ADDR_U0_LOW, 8'hfe);
    wr(`DTC_ADDR_U0_HIGH, 8'hff);
    wr(`DTC_ADDR_CONTROL, 8'h10);
    wait_ovf(0);
    rd16(`DTC_ADDR_U0_LOW);
    `CHK("reload high", 8'hff, cnt_q[15:8])
    `CHK("reload low", 1'b1, cnt_q[7:0] >= 8'hfc)
    `CHK("flag with oe", 1'b0, fl_q[5])
    `CHK("wave toggled", 1'b1, wave0_w)
    $display("test mode0 done");
    wr(`DTC_ADDR_EXT_STATUS, 8'h00);
    wr(`DTC_ADDR_MODE_SEL, 8'h20);
    wr(`DTC_ADDR_U1_RLD_LO, 8'hf0);
    wr(`DTC_ADDR_U1_HIGH, 8'h5a);
    wr(`DTC_ADDR_U1_LOW, 8'hfe);
    wr(`DTC_ADDR_CONTROL, 8'h40);
    wait_ovf(1);
    rd16(`DTC_ADDR_U1_LOW);
    `CHK("mode2 high kept", 8'h5a, cnt_q[15:8])
    `CHK("mode2 low reload", 4'hf, cnt_q[7:4])
    `CHK("mode2 flag", 1'b1, fl_q[7])
    $display("test mode2 done");
    wr(`DTC_ADDR_CONTROL, 8'h00);
    wr(`DTC_ADDR_MODE_SEL, 8'h33);
    wr(`DTC_ADDR_U1_LOW, 8'h33);
    wr(`DTC_ADDR_U0_LOW, 8'h00);
    wr(`DTC_ADDR_U0_HIGH, 8'hfe);
    wr(`DTC_ADDR_CONTROL, 8'h50);
    wait_ovf(1);
    rd(`DTC_ADDR_U1_LOW);
    `CHK("mode3 unit1 held", 8'h33, rd_q[7:0])
    `CHK("mode3 flags", 2'b10, {fl_q[7], fl_q[5]})
    // split high byte again, now with unit 1 output enable set
    wr(`DTC_ADDR_EXT_STATUS, 8'h04);
    wr(`DTC_ADDR_U0_HIGH, 8'hfe);
    wr(`DTC_ADDR_CONTROL, 8'h40);
    wait_ovf(1);
    `CHK("wave1 toggled", 1'b1, wave1_w)
    `CHK("flag1 with oe", 1'b0, fl_q[7])
    $display("test mode3 done");
    summarize;
  end
endmodule // tb
